// ==== rtl/ffp_flash_guard.v ====
// Function
// R1: double fault or collision sets double flag
// R2: writing one clears double flag
// R3: single fault sets single flag unless ignored
// R4: writing one clears single flag
// R5: parity fault sets one flag only
// R6: collision sets both flags together
// R7: flags stored one cycle after read
// R8: software waits one instruction before checking
// R9: protection writes may only enlarge region
// R10: protection loaded from configuration byte
// R11: double fault on load gives full protection
// R12: protected program/erase refused, violation flagged
// R13: block erase refused if anything protected
// R14: bit 7 selects protect or unprotect ranges
// R15: bit 5 disables the high range
// R16: high size writable only while disabled
// R17: high size 2K to 16K at top
// R18: bit 2 disables the low range
// R19: low size writable only while disabled
// R20: low size 1K to 8K at base
// R21: software leaves reserved bit 6 erased
// R22: flag with enable requests an interrupt
// R23: disallowed scenario writes ignored entirely
// R24: set wins over clearing write
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "ffp_defines.vh"

module ffp_flash_guard (
  input wire clock,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`FFP_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rd_valid,
  input wire rd_single_fault,
  input wire rd_double_fault,
  input wire rd_collision,
  input wire cfg_load_valid,
  input wire [7:0] cfg_load_byte,
  input wire cfg_load_dfault,
  input wire pe_req,
  input wire [`FFP_PADDR_W-1:0] pe_addr,
  input wire pe_block_erase,
  output reg pe_grant,
  output reg pe_refused,
  output wire single_fault_irq,
  output wire double_fault_irq
);

  // one-hot word decode; index is paddr[5:2], upper bits must be zero
  function hit;
    input [`FFP_ADDR_W-1:0] a;
    input [3:0] idx;
    begin
      hit = (a[1:0] == 2'h0) && (a[5:2] == idx) &&
            (a[`FFP_ADDR_W-1:6] == {(`FFP_ADDR_W-6){1'b0}});
    end
  endfunction

  // true when a protected range keeps or widens (opsel stays set)
  function range_grows;
    input old_dis;
    input new_dis;
    input [1:0] old_sz;
    input [1:0] new_sz;
    begin
      range_grows = old_dis || (!new_dis && (new_sz >= old_sz));
    end
  endfunction

  // true when an unprotected range vanishes or shrinks (opsel stays clear)
  function range_shrinks;
    input old_dis;
    input new_dis;
    input [1:0] old_sz;
    input [1:0] new_sz;
    begin
      range_shrinks = new_dis || (!old_dis && (new_sz <= old_sz));
    end
  endfunction

  // true when any part of the array is protected under prot
  function any_protected;
    input [7:0] prot;
    begin
      // only opsel set with both ranges off leaves everything open
      any_protected = !(prot[`FFP_BIT_OPSEL] && prot[`FFP_BIT_HDIS] &&
                        prot[`FFP_BIT_LDIS]);
    end
  endfunction

  // true when addr lies in the protected area described by prot
  function is_protected;
    input [`FFP_PADDR_W-1:0] addr;
    input [7:0] prot;
    reg [`FFP_PADDR_W:0] hi_start;
    reg [`FFP_PADDR_W-1:0] lo_end;
    reg in_hi;
    reg in_lo;
    begin
      // R17: high range ends at the top
      hi_start = `FFP_TOP_END -
        ({1'b0, `FFP_HIGH_UNIT} << prot[`FFP_BIT_HS_HI:`FFP_BIT_HS_LO]);
      // R20: low range starts at the base
      lo_end = `FFP_LOW_BASE +
        (`FFP_LOW_UNIT << prot[`FFP_BIT_LS_HI:`FFP_BIT_LS_LO]);
      // R15: high range enable
      in_hi = !prot[`FFP_BIT_HDIS] && ({1'b0, addr} >= hi_start);
      // R18: low range enable
      in_lo = !prot[`FFP_BIT_LDIS] && (addr >= `FFP_LOW_BASE) &&
              (addr < lo_end);
      // R14: operation select
      if (prot[`FFP_BIT_OPSEL])
        is_protected = in_hi || in_lo;
      else
        is_protected = !(in_hi || in_lo);
    end
  endfunction

  reg [1:0] fault_r;
  reg [1:0] fault_nxt;
  reg [1:0] pend_r;
  reg [1:0] pend_nxt;
  reg ignore_sf_r;
  reg [1:0] irq_en_r;
  reg pviol_r;
  reg pviol_nxt;
  reg [7:0] prot_r;
  reg [7:0] prot_nxt;
  reg loaded_r;
  reg [7:0] cand;
  reg allow;
  reg [31:0] rdata_nxt;
  reg refuse;

  wire wr_acc = psel && penable && pwrite;
  wire setup = psel && !penable;
  wire sel_cfg = hit(paddr, `FFP_IDX_FLASH_CONFIG);
  wire sel_ien = hit(paddr, `FFP_IDX_IRQ_ENABLE);
  wire sel_mst = hit(paddr, `FFP_IDX_MAIN_STATUS);
  wire sel_fst = hit(paddr, `FFP_IDX_FAULT_STATUS);
  wire sel_prt = hit(paddr, `FFP_IDX_PROTECTION);
  wire mapped = sel_cfg | sel_ien | sel_mst | sel_fst | sel_prt;
  wire fst_wr = wr_acc && sel_fst;
  wire prt_wr = wr_acc && sel_prt;
  wire mst_wr = wr_acc && sel_mst;
  // first configuration byte after reset only
  wire load_now = cfg_load_valid && !loaded_r;

  // protection fields of the current value
  wire cur_hdis = prot_r[`FFP_BIT_HDIS];
  wire cur_ldis = prot_r[`FFP_BIT_LDIS];
  wire [1:0] cur_hs = prot_r[`FFP_BIT_HS_HI:`FFP_BIT_HS_LO];
  wire [1:0] cur_ls = prot_r[`FFP_BIT_LS_HI:`FFP_BIT_LS_LO];

  // zero-wait slave; unmapped address answers with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // R22: interrupt requests, one per flag
  wire [1:0] irq_vec;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_irq
      assign irq_vec[g] = fault_r[g] & irq_en_r[g];
    end
  endgenerate
  assign single_fault_irq = irq_vec[`FFP_BIT_SINGLE];
  assign double_fault_irq = irq_vec[`FFP_BIT_DOUBLE];

  // event classification for the staging flop
  always @* begin
    pend_nxt = 2'h0;
    if (rd_valid) begin
      if (rd_collision) begin
        // R6: collision sets both
        pend_nxt = 2'h3;
      end else if (rd_double_fault) begin
        // R1: double fault
        pend_nxt[`FFP_BIT_DOUBLE] = 1'b1;
      end else if (rd_single_fault && !ignore_sf_r) begin
        // R3: single fault when not ignored
        // R5: never together with double
        pend_nxt[`FFP_BIT_SINGLE] = 1'b1;
      end
    end
  end

  // fault flags: write-one-to-clear, set wins
  always @* begin
    fault_nxt = fault_r;
    if (fst_wr) begin
      // R2: clear double by one
      // R4: clear single by one
      fault_nxt = fault_r & ~pwdata[1:0];
    end
    // R7: staged event lands one cycle later
    // R24: set over clear
    fault_nxt = fault_nxt | pend_r;
  end

  // candidate protection value and monotonic check
  always @* begin
    cand = prot_r;
    cand[`FFP_BIT_OPSEL] = pwdata[`FFP_BIT_OPSEL];
    cand[`FFP_BIT_HDIS] = pwdata[`FFP_BIT_HDIS];
    cand[`FFP_BIT_LDIS] = pwdata[`FFP_BIT_LDIS];
    // R16: high size only while high range disabled
    if (prot_r[`FFP_BIT_HDIS])
      cand[`FFP_BIT_HS_HI:`FFP_BIT_HS_LO] =
        pwdata[`FFP_BIT_HS_HI:`FFP_BIT_HS_LO];
    // R19: low size only while low range disabled
    if (prot_r[`FFP_BIT_LDIS])
      cand[`FFP_BIT_LS_HI:`FFP_BIT_LS_LO] =
        pwdata[`FFP_BIT_LS_HI:`FFP_BIT_LS_LO];
    // R9: protected region may only grow
    if (prot_r[`FFP_BIT_OPSEL] && cand[`FFP_BIT_OPSEL]) begin
      // protected ranges must keep or widen
      allow = range_grows(cur_hdis, cand[`FFP_BIT_HDIS], cur_hs,
                          cand[`FFP_BIT_HS_HI:`FFP_BIT_HS_LO]) &&
              range_grows(cur_ldis, cand[`FFP_BIT_LDIS], cur_ls,
                          cand[`FFP_BIT_LS_HI:`FFP_BIT_LS_LO]);
    end else if (!prot_r[`FFP_BIT_OPSEL] && !cand[`FFP_BIT_OPSEL]) begin
      // unprotected ranges must keep or shrink
      allow = range_shrinks(cur_hdis, cand[`FFP_BIT_HDIS], cur_hs,
                            cand[`FFP_BIT_HS_HI:`FFP_BIT_HS_LO]) &&
              range_shrinks(cur_ldis, cand[`FFP_BIT_LDIS], cur_ls,
                            cand[`FFP_BIT_LS_HI:`FFP_BIT_LS_LO]);
    end else if (prot_r[`FFP_BIT_OPSEL]) begin
      // new unprotected ranges must avoid old protected ranges
      allow = (cand[`FFP_BIT_HDIS] || prot_r[`FFP_BIT_HDIS]) &&
              (cand[`FFP_BIT_LDIS] || prot_r[`FFP_BIT_LDIS]);
    end else begin
      // leaving full-style protection for ranges only always shrinks
      allow = 1'b0;
    end
  end

  // protection register update
  always @* begin
    prot_nxt = prot_r;
    if (load_now) begin
      // R10: load from configuration byte
      // R11: double fault forces full protection
      prot_nxt = cfg_load_dfault ? `FFP_PROT_FULL : cfg_load_byte;
    end else if (prt_wr && allow) begin
      // R23: only allowed scenarios are taken
      prot_nxt = cand;
    end
  end

  // program/erase screening
  always @* begin
    if (pe_block_erase) begin
      // R13: any protected sector blocks erase
      refuse = any_protected(prot_r);
    end else begin
      refuse = is_protected(pe_addr, prot_r);
    end
    pviol_nxt = pviol_r;
    if (mst_wr && pwdata[`FFP_BIT_PVIOL])
      pviol_nxt = 1'b0;
    // R12: refused request flags violation, set wins
    if (pe_req && refuse)
      pviol_nxt = 1'b1;
  end

  // read data mux, captured in the setup phase
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (sel_cfg)
      rdata_nxt[`FFP_BIT_IGNORE_SF] = ignore_sf_r;
    if (sel_ien)
      rdata_nxt[1:0] = irq_en_r;
    if (sel_mst)
      rdata_nxt[`FFP_BIT_PVIOL] = pviol_r;
    if (sel_fst)
      rdata_nxt[1:0] = fault_r;
    if (sel_prt)
      rdata_nxt[7:0] = prot_r;
  end

  // R7: fault staging and flags
  always @(posedge clock) begin
    if (sys_rst) begin
      pend_r <= 2'h0;
      fault_r <= 2'h0;
    end else begin
      pend_r <= pend_nxt;
      fault_r <= fault_nxt;
    end
  end

  // protection state and violation flag
  always @(posedge clock) begin
    if (sys_rst) begin
      prot_r <= `FFP_PROT_FULL;
      loaded_r <= 1'b0;
      pviol_r <= 1'b0;
    end else begin
      prot_r <= prot_nxt;
      pviol_r <= pviol_nxt;
      if (cfg_load_valid)
        loaded_r <= 1'b1;
    end
  end

  // software control bits
  always @(posedge clock) begin
    if (sys_rst) begin
      ignore_sf_r <= 1'b0;
      irq_en_r <= 2'h0;
    end else begin
      if (wr_acc && sel_cfg)
        ignore_sf_r <= pwdata[`FFP_BIT_IGNORE_SF];
      if (wr_acc && sel_ien)
        irq_en_r <= pwdata[1:0];
    end
  end

  // read data is captured in the setup phase of a read
  always @(posedge clock) begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rdata_nxt;
  end

  // program/erase answers, one-cycle pulses
  always @(posedge clock) begin
    if (sys_rst) begin
      pe_grant <= 1'b0;
      pe_refused <= 1'b0;
    end else begin
      pe_grant <= pe_req && !refuse;
      pe_refused <= pe_req && refuse;
    end
  end

endmodule

// ==== rtl/ffp_defines.vh ====
`ifndef FFP_DEFINES_VH
`define FFP_DEFINES_VH

// register indices (byte address is four times the index)
`define FFP_IDX_FLASH_CONFIG 4'h4
`define FFP_IDX_IRQ_ENABLE 4'h5
`define FFP_IDX_MAIN_STATUS 4'h6
`define FFP_IDX_FAULT_STATUS 4'h7
`define FFP_IDX_PROTECTION 4'h8
`define FFP_ADDR_W 12

// fault status and irq enable bit positions
`define FFP_BIT_SINGLE 0
`define FFP_BIT_DOUBLE 1
// flash config bit position
`define FFP_BIT_IGNORE_SF 4
// main status bit position
`define FFP_BIT_PVIOL 4

// protection register field positions
`define FFP_BIT_OPSEL 7
`define FFP_BIT_RSVD 6
`define FFP_BIT_HDIS 5
`define FFP_BIT_HS_HI 4
`define FFP_BIT_HS_LO 3
`define FFP_BIT_LDIS 2
`define FFP_BIT_LS_HI 1
`define FFP_BIT_LS_LO 0

// reset and double-fault load value: operation select clear, rest set
`define FFP_PROT_FULL 8'h7f

// program flash address map (18-bit global addresses)
`define FFP_PADDR_W 18
`define FFP_LOW_BASE 18'h38000
`define FFP_TOP_END 19'h40000
`define FFP_LOW_UNIT 18'h00400
`define FFP_HIGH_UNIT 18'h00800

`endif

// ==== verification/ffp_guard_asserts.sv ====
`timescale 1ns/1ps
module ffp_guard_asserts (
  input wire clock,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pslverr,
  input wire rd_valid,
  input wire rd_single_fault,
  input wire rd_double_fault,
  input wire rd_collision,
  input wire pe_req,
  input wire pe_grant,
  input wire pe_refused,
  input wire single_fault_irq,
  input wire double_fault_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire apw = psel & penable & pwrite;
  a_pe_excl: assert property (!(pe_grant && pe_refused))
    else $error("grant and refusal together");
  a_pe_answer: assert property (pe_req |=> pe_grant || pe_refused)
    else $error("request not answered");
  a_pe_origin: assert property ((pe_grant || pe_refused) |-> $past(pe_req))
    else $error("answer without request");
  a_dirq_cause: assert property ($rose(double_fault_irq) |-> $past(apw) ||
    ($past(rd_valid, 2) && $past(rd_double_fault | rd_collision, 2)))
    else $error("double irq without cause");
  a_sirq_cause: assert property ($rose(single_fault_irq) |-> $past(apw) ||
    ($past(rd_valid, 2) && $past(rd_single_fault | rd_collision, 2)))
    else $error("single irq without cause");
  a_dirq_clear: assert property ($fell(double_fault_irq) |-> $past(apw))
    else $error("double irq fell without write");
  a_sirq_clear: assert property ($fell(single_fault_irq) |-> $past(apw))
    else $error("single irq fell without write");
  a_map_ok: assert property (psel && penable && paddr == 12'h01c |-> !pslverr)
    else $error("fault status reported unmapped");
  cover property (pe_refused);
  cover property (pe_grant);
  cover property ($rose(double_fault_irq));
endmodule

bind ffp_flash_guard ffp_guard_asserts i_chk (.*);

// ==== verification/ffp_flash_guard_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module ffp_flash_guard_tb_top;
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] r;
    logic [17:0] a;
    logic be;
    logic rf;
  } ffp_row_t;
  logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rv;
  logic pready, pslverr, ev;
  logic rd_valid = 0, rd_s = 0, rd_d = 0, rd_c = 0;
  logic ld_v = 0, ld_df = 0, pe_req = 0, pe_be = 0;
  logic [7:0] ld_b = 0;
  logic [17:0] pe_addr = 0;
  logic pe_grant, pe_refused, sirq, dirq;
  int fails = 0, n_tests = 0;
  ffp_row_t rows[5] = '{'{8'hff, 8'hff, 18'h3c000, 1'b1, 1'b0},
    '{8'hdf, 8'hdf, 18'h3c000, 1'b0, 1'b1}, '{8'hda, 8'hda, 18'h38fff, 1'b0, 1'b1},
    '{8'hda, 8'hda, 18'h39000, 1'b0, 1'b0}, '{8'hff, 8'hda, 18'h3bfff, 1'b1, 1'b1}};
  ffp_flash_guard i_ffp_flash_guard (.clock(clock), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rd_valid(rd_valid), .rd_single_fault(rd_s), .rd_double_fault(rd_d),
    .rd_collision(rd_c), .cfg_load_valid(ld_v), .cfg_load_byte(ld_b),
    .cfg_load_dfault(ld_df), .pe_req(pe_req), .pe_addr(pe_addr),
    .pe_block_erase(pe_be), .pe_grant(pe_grant), .pe_refused(pe_refused),
    .single_fault_irq(sirq), .double_fault_irq(dirq));
  initial forever #4 clock = ~clock;
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rv = prdata; ev = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic restart(input logic [7:0] b, input logic df);
    sys_rst <= 1;
    repeat (16) @(posedge clock);
    sys_rst <= 0; ld_v <= 1; ld_b <= b; ld_df <= df;
    @(posedge clock);
    ld_v <= 0;
  endtask
  task automatic pe(input logic [17:0] a, input logic be);
    @(posedge clock);
    pe_req <= 1; pe_addr <= a; pe_be <= be;
    @(posedge clock);
    pe_req <= 0;
    #1;
  endtask
  task automatic rd(input logic s, input logic d, input logic c);
    @(posedge clock);
    rd_valid <= 1; rd_s <= s; rd_d <= d; rd_c <= c;
    @(posedge clock);
    rd_valid <= 0;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    summarize;
  end
  initial begin
    restart(8'hff, 1'b0);
    apb(0, 12'h020, 0); `CHK(rv[7:0], 8'hff)
    foreach (rows[i]) begin
      apb(1, 12'h020, rows[i].w);
      apb(0, 12'h020, 0); `CHK(rv[7:0], rows[i].r)
      pe(rows[i].a, rows[i].be); `CHK(pe_refused, rows[i].rf)
    end
    apb(0, 12'h018, 0); `CHK(rv[4], 1'b1)
    apb(1, 12'h014, 8'h03);
    rd(0, 1, 0); #1 `CHK(dirq, 1'b0)
    @(posedge clock); #1 `CHK(dirq, 1'b1)
    apb(1, 12'h01c, 8'h00); apb(0, 12'h01c, 0); `CHK(rv[1:0], 2'h2)
    apb(1, 12'h01c, 8'h02); apb(0, 12'h01c, 0); `CHK(rv[1:0], 2'h0)
    rd(1, 1, 0); @(posedge clock);
    apb(0, 12'h01c, 0); `CHK(rv[1:0], 2'h2)
    apb(1, 12'h01c, 8'h03); rd(1, 0, 1); @(posedge clock);
    apb(0, 12'h01c, 0); `CHK(rv[1:0], 2'h3)
    apb(1, 12'h01c, 8'h02); apb(0, 12'h01c, 0); `CHK(rv[1:0], 2'h1)
    apb(1, 12'h01c, 8'h01); rd(1, 0, 0); @(posedge clock);
    apb(0, 12'h01c, 0); `CHK(rv[1:0], 2'h1)
    apb(1, 12'h01c, 8'h01); apb(1, 12'h010, 8'h10); rd(1, 0, 0);
    @(posedge clock); apb(0, 12'h01c, 0); `CHK(rv[1:0], 2'h0)
    apb(0, 12'h03c, 0); `CHK(ev, 1'b1)
    restart(8'hff, 1'b1);
    apb(1, 12'h020, 8'hff); apb(0, 12'h020, 0); `CHK(rv[7:0], 8'h7f)
    pe(18'h20000, 1'b0); `CHK(pe_refused, 1'b1)
    summarize;
  end
endmodule
